// ### logic/timer_one_pkg.sv
// constants for the sixteen-bit timer/counter block
// assumes a classic wishbone master with 32-bit data and a 10 MHz system clock
//
// Functional notes
// - wide mode gives atomic sixteen-bit count access
// - divider field picks 1:1, 1:2, 1:4, 1:8
// - sync bypass counts external edges unsynchronised
// - internal source ignores the sync bypass bit
// - internal source counts once per instruction cycle
// - external source counts input or oscillator rising edges
// - run bit starts and stops counting
// - oscillator enable bit switches crystal oscillator
// - oscillator on forces pins input, reads zero
// - oscillator keeps running during sleep
// - count runs 0000h to FFFFh then wraps
// - each wrap sets latched overflow flag bit 0
// - interrupt request only while enable bit set
// - control bit six reads back as zero
// - compare unit reset input clears the count
// - wide low read copies high into buffer
// - wide high write buffered, applied on low write
// - low byte write clears prescaler, high not
// - trigger clears count, no flag, write wins
package timer_one_pkg;

	// register byte offsets, one aligned word each
	localparam logic [7:0] OFS_CONTROL    = 8'h00;
	localparam logic [7:0] OFS_COUNT_LOW  = 8'h04;
	localparam logic [7:0] OFS_COUNT_HIGH = 8'h08;
	localparam logic [7:0] OFS_FLAG       = 8'h0C;
	localparam logic [7:0] OFS_ENABLE     = 8'h10;
	localparam logic [7:0] OFS_PORT_C     = 8'h14;

	// control register fields
	localparam int CTRL_WIDE    = 7;
	localparam int CTRL_UNUSED  = 6;
	localparam int CTRL_DIV_LSB = 4;
	localparam int CTRL_OSC     = 3;
	localparam int CTRL_BYPASS  = 2;
	localparam int CTRL_SRC     = 1;
	localparam int CTRL_RUN     = 0;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] CONTROL_WMASK = 8'hBF;

	localparam int FLAG_BIT   = 0;
	localparam int ENABLE_BIT = 0;

	// port c register: direction, output latch, pin levels
	localparam int PORT_DIR_LSB = 0;
	localparam int PORT_LAT_LSB = 2;
	localparam int PORT_PIN_LSB = 4;
	localparam logic [1:0] PORT_DIR_RESET = 2'h3;
	localparam int PIN_OSC_OUT = 0;
	localparam int PIN_OSC_IN  = 1;

	// divider codes
	localparam logic [1:0] DIV_1 = 2'h0;
	localparam logic [1:0] DIV_2 = 2'h1;
	localparam logic [1:0] DIV_4 = 2'h2;
	localparam logic [1:0] DIV_8 = 2'h3;

	// system clocks per instruction cycle
	localparam int INSTR_DIV = 4;
	localparam logic [1:0] INSTR_LAST = 2'(INSTR_DIV - 1);

	localparam logic [15:0] COUNT_ZERO = 16'h0000;
	localparam logic [15:0] COUNT_MAX  = 16'hFFFF;

endpackage

// ### logic/count_path_if.sv
// carries the count clock path between the core, edge detector and prescaler
// assumes all three sit on the same system clock
`timescale 1ns/100ps
interface count_path_if;
	logic       ext_rise;
	logic       raw_tick;
	logic [1:0] div_sel;
	logic       pre_clear;
	logic       count_tick;

	modport edge_mp (output ext_rise);
	modport pre_mp  (input raw_tick, input div_sel, input pre_clear, output count_tick);
	modport core_mp (input ext_rise, input count_tick, output raw_tick, output div_sel,
		output pre_clear);
endinterface // count_path_if

// ### logic/ext_edge_detect.sv
// rising edge detector for the external count source
// assumes the selected source level is sampled on sys_clk
`timescale 1ns/100ps
module ext_edge_detect (
	input  wire logic     sys_clk,
	input  wire logic     resetn,
	input  wire logic     ext_level,
	input  wire logic     sync_bypass,
	input  wire logic     sleep_mode,
	count_path_if.edge_mp cp
);
	typedef struct packed {
		logic sync1;
		logic sync2;
		logic prev_sync;
		logic prev_raw;
	} edge_state_t;

	edge_state_t cur_ff;
	edge_state_t nxt_ff;

	always_comb begin
		nxt_ff           = cur_ff;
		nxt_ff.sync1     = ext_level;
		nxt_ff.sync2     = cur_ff.sync1;
		nxt_ff.prev_sync = cur_ff.sync2;
		nxt_ff.prev_raw  = ext_level;
	end

	// bypass or synchroniser
	// the synchronised path needs the instruction clock, so it stops in sleep
	assign cp.ext_rise = sync_bypass ? (ext_level & ~cur_ff.prev_raw)
		: (~sleep_mode & cur_ff.sync2 & ~cur_ff.prev_sync);

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_ff;
		end
	end
endmodule // ext_edge_detect

// ### logic/input_prescaler.sv
// 1:1 to 1:8 prescaler ahead of the sixteen-bit counter
// assumes raw_tick is a one-cycle pulse
`timescale 1ns/100ps
module input_prescaler (
	input  wire logic    sys_clk,
	input  wire logic    resetn,
	count_path_if.pre_mp cp
);
	typedef struct packed {
		logic [2:0] cnt;
	} pre_state_t;

	pre_state_t cur_ff;
	pre_state_t nxt_ff;
	logic [2:0] last;

	always_comb begin
		case (cp.div_sel)
			timer_one_pkg::DIV_1: last = 3'h0;
			timer_one_pkg::DIV_2: last = 3'h1;
			timer_one_pkg::DIV_4: last = 3'h3;
			default:              last = 3'h7;
		endcase
	end

	always_comb begin
		nxt_ff = cur_ff;
		if (cp.pre_clear) begin
			nxt_ff.cnt = 3'h0;
		end else if (cp.raw_tick) begin
			nxt_ff.cnt = (cur_ff.cnt >= last) ? 3'h0 : cur_ff.cnt + 3'h1;
		end
	end

	assign cp.count_tick = cp.raw_tick & ~cp.pre_clear & (cur_ff.cnt >= last);

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_ff;
		end
	end

	default clocking dc @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	a_pre_clear_zero: assert property (cp.pre_clear |=> cur_ff.cnt == 3'h0)
		else $error("prescaler not cleared");
	a_div_eight_rate: assert property (
		cp.count_tick && cp.div_sel == timer_one_pkg::DIV_8 |-> cur_ff.cnt == 3'h7)
		else $error("1:8 tick at wrong prescale count");
endmodule // input_prescaler

// ### logic/timer_one_core.sv
// sixteen-bit timer/counter with wishbone register access
// assumes a classic wishbone master; pins are synchronous to sys_clk
`timescale 1ns/100ps
module timer_one_core (
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [1:0]  pin_in,
	output logic      [1:0]  pin_out,
	output logic      [1:0]  pin_oe,
	input  wire logic        sleep_mode,
	input  wire logic        special_event_trigger,
	output logic             overflow_irq,
	output logic             low_power_osc_enable,
	output logic      [15:0] count_value
);
	typedef struct packed {
		logic        ack;
		logic [31:0] rdata;
		logic [7:0]  ctrl;
		logic [15:0] count;
		logic [7:0]  high_buf;
		logic        flag;
		logic        irq_en;
		logic [1:0]  port_dir;
		logic [1:0]  port_lat;
		logic [1:0]  instr_div;
		logic        irq;
		logic        osc_on;
		logic [1:0]  pin_out;
		logic [1:0]  pin_oe;
	} core_state_t;

	core_state_t  cur_ff;
	core_state_t  nxt_ff;
	count_path_if cp ();

	logic       req;
	logic       wr;
	logic       rd;
	logic [7:0] wbyte;
	logic       wide;
	logic       instr_tick;
	logic       src_tick;
	logic       ovf_set;
	logic       ext_level;
	logic [1:0] pins_read;

	////////////////////////////////////////////////////////////////////////////
	// bus decode

	// one wait state: ack rises the cycle after the request appears
	assign req   = wb_cyc_i & wb_stb_i & ~cur_ff.ack;
	assign wr    = req & wb_we_i & wb_sel_i[0];
	assign rd    = req & ~wb_we_i;
	assign wbyte = wb_dat_i[7:0];
	assign wide  = cur_ff.ctrl[timer_one_pkg::CTRL_WIDE];

	////////////////////////////////////////////////////////////////////////////
	// count clock path

	assign instr_tick = ~sleep_mode & (cur_ff.instr_div == timer_one_pkg::INSTR_LAST);

	assign ext_level = cur_ff.ctrl[timer_one_pkg::CTRL_OSC]
		? pin_in[timer_one_pkg::PIN_OSC_IN] : pin_in[timer_one_pkg::PIN_OSC_OUT];

	assign src_tick = cur_ff.ctrl[timer_one_pkg::CTRL_SRC] ? cp.ext_rise : instr_tick;

	assign cp.raw_tick = cur_ff.ctrl[timer_one_pkg::CTRL_RUN] & src_tick;
	assign cp.div_sel  = cur_ff.ctrl[timer_one_pkg::CTRL_DIV_LSB +: 2];

	assign cp.pre_clear = wr & (wb_adr_i == timer_one_pkg::OFS_COUNT_LOW);

	ext_edge_detect u_edge (
		.sys_clk     (sys_clk),
		.resetn      (resetn),
		.ext_level   (ext_level),
		.sync_bypass (cur_ff.ctrl[timer_one_pkg::CTRL_BYPASS]),
		.sleep_mode  (sleep_mode),
		.cp          (cp.edge_mp)
	);

	input_prescaler u_pre (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.cp      (cp.pre_mp)
	);

	assign pins_read = cur_ff.osc_on ? 2'h0 : pin_in;

	assign ovf_set = cp.count_tick & (cur_ff.count == timer_one_pkg::COUNT_MAX);

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		nxt_ff     = cur_ff;
		nxt_ff.ack = req;

		if (sleep_mode || cur_ff.instr_div == timer_one_pkg::INSTR_LAST) begin
			nxt_ff.instr_div = 2'h0;
		end else begin
			nxt_ff.instr_div = cur_ff.instr_div + 2'h1;
		end

		// no tick while stopped, so the value holds
		if (cp.count_tick) begin
			nxt_ff.count = cur_ff.count + 16'h0001;
		end

		if (special_event_trigger) begin
			nxt_ff.count = timer_one_pkg::COUNT_ZERO;
		end

		// writes come after the trigger so a coinciding write wins
		if (wr) begin
			case (wb_adr_i)
				timer_one_pkg::OFS_CONTROL: begin
					nxt_ff.ctrl = wbyte & timer_one_pkg::CONTROL_WMASK;
				end
				timer_one_pkg::OFS_COUNT_LOW: begin
					nxt_ff.count[7:0] = wbyte;
					// buffer moves in with low write
					if (wide) begin
						nxt_ff.count[15:8] = cur_ff.high_buf;
					end
				end
				timer_one_pkg::OFS_COUNT_HIGH: begin
					// wide mode goes through the buffer
					if (wide) begin
						nxt_ff.high_buf = wbyte;
					end else begin
						nxt_ff.count[15:8] = wbyte;
					end
				end
				timer_one_pkg::OFS_FLAG: begin
					nxt_ff.flag = wbyte[timer_one_pkg::FLAG_BIT];
				end
				timer_one_pkg::OFS_ENABLE: begin
					nxt_ff.irq_en = wbyte[timer_one_pkg::ENABLE_BIT];
				end
				timer_one_pkg::OFS_PORT_C: begin
					nxt_ff.port_dir = wbyte[timer_one_pkg::PORT_DIR_LSB +: 2];
					nxt_ff.port_lat = wbyte[timer_one_pkg::PORT_LAT_LSB +: 2];
				end
				default: begin
					nxt_ff.flag = nxt_ff.flag;
				end
			endcase
		end

		// set wins over a clearing write
		if (ovf_set) begin
			nxt_ff.flag = 1'b1;
		end

		// low read snapshots the high byte
		if (rd && wide && wb_adr_i == timer_one_pkg::OFS_COUNT_LOW) begin
			nxt_ff.high_buf = cur_ff.count[15:8];
		end

		nxt_ff.rdata = 32'h0000_0000;
		if (rd) begin
			case (wb_adr_i)
				timer_one_pkg::OFS_CONTROL:    nxt_ff.rdata[7:0] = cur_ff.ctrl;
				timer_one_pkg::OFS_COUNT_LOW:  nxt_ff.rdata[7:0] = cur_ff.count[7:0];
				timer_one_pkg::OFS_COUNT_HIGH: begin
					nxt_ff.rdata[7:0] = wide ? cur_ff.high_buf : cur_ff.count[15:8];
				end
				timer_one_pkg::OFS_FLAG: begin
					nxt_ff.rdata[timer_one_pkg::FLAG_BIT] = cur_ff.flag;
				end
				timer_one_pkg::OFS_ENABLE: begin
					nxt_ff.rdata[timer_one_pkg::ENABLE_BIT] = cur_ff.irq_en;
				end
				timer_one_pkg::OFS_PORT_C: begin
					nxt_ff.rdata[timer_one_pkg::PORT_DIR_LSB +: 2] = cur_ff.port_dir;
					nxt_ff.rdata[timer_one_pkg::PORT_LAT_LSB +: 2] = cur_ff.port_lat;
					nxt_ff.rdata[timer_one_pkg::PORT_PIN_LSB +: 2] = pins_read;
				end
				// unmapped addresses still ack and read zero
				default: nxt_ff.rdata = 32'h0000_0000;
			endcase
		end

		nxt_ff.irq = nxt_ff.flag & nxt_ff.irq_en;

		// sleep_mode does not reach the oscillator enable
		nxt_ff.osc_on = nxt_ff.ctrl[timer_one_pkg::CTRL_OSC];

		nxt_ff.pin_oe  = nxt_ff.osc_on ? 2'h0 : ~nxt_ff.port_dir;
		nxt_ff.pin_out = nxt_ff.port_lat;
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			cur_ff          <= '0;
			cur_ff.ctrl     <= timer_one_pkg::CONTROL_RESET;
			cur_ff.port_dir <= timer_one_pkg::PORT_DIR_RESET;
		end else begin
			cur_ff <= nxt_ff;
		end
	end

	assign wb_ack_o             = cur_ff.ack;
	assign wb_dat_o             = cur_ff.rdata;
	assign overflow_irq         = cur_ff.irq;
	assign low_power_osc_enable = cur_ff.osc_on;
	assign count_value          = cur_ff.count;
	assign pin_out              = cur_ff.pin_out;
	assign pin_oe               = cur_ff.pin_oe;

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking dc @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	logic wr_count;
	assign wr_count = wr & (wb_adr_i == timer_one_pkg::OFS_COUNT_LOW
		|| wb_adr_i == timer_one_pkg::OFS_COUNT_HIGH);

	a_bit_six_zero: assert property (
		rd && wb_adr_i == timer_one_pkg::OFS_CONTROL |=> wb_ack_o && wb_dat_o[6] == 1'b0)
		else $error("control bit six read as one");
	a_count_wraps: assert property (
		ovf_set && !special_event_trigger && !wr_count |=> count_value == 16'h0000)
		else $error("count did not wrap to zero");
	a_wrap_sets_flag: assert property (ovf_set |=> cur_ff.flag)
		else $error("wrap did not set overflow flag");
	a_trigger_no_flag: assert property (
		special_event_trigger && !cur_ff.flag && !wr ##0 !ovf_set
		|=> !cur_ff.flag && count_value == 16'h0000)
		else $error("trigger misbehaved");
	a_write_wins: assert property (
		special_event_trigger && wr && wb_adr_i == timer_one_pkg::OFS_COUNT_LOW
		|=> count_value[7:0] == $past(wb_dat_i[7:0]))
		else $error("trigger beat a count write");
	a_stopped_holds: assert property (
		!cur_ff.ctrl[timer_one_pkg::CTRL_RUN] && !special_event_trigger && !wr_count
		|=> $stable(count_value))
		else $error("stopped counter moved");
	a_irq_gated: assert property (
		overflow_irq == (cur_ff.irq_en && cur_ff.flag))
		else $error("interrupt does not follow flag and enable");
	a_wide_snapshot: assert property (
		rd && wide && wb_adr_i == timer_one_pkg::OFS_COUNT_LOW
		|=> cur_ff.high_buf == $past(count_value[15:8]))
		else $error("high byte not snapshotted");
	a_wide_commit: assert property (
		wr && wide && wb_adr_i == timer_one_pkg::OFS_COUNT_LOW
		|=> count_value[15:8] == $past(cur_ff.high_buf))
		else $error("buffered high byte not applied");
	a_osc_pins_in: assert property (low_power_osc_enable |-> pin_oe == 2'h0)
		else $error("oscillator pins driven");
	a_internal_src: assert property (
		cp.raw_tick && !cur_ff.ctrl[timer_one_pkg::CTRL_SRC] |-> instr_tick)
		else $error("internal source counted a foreign tick");

	c_wrap: cover property (ovf_set);
	c_trigger: cover property (special_event_trigger && count_value != 16'h0000);
	c_wide_read: cover property (rd && wide && wb_adr_i == timer_one_pkg::OFS_COUNT_LOW);
	c_ext_count: cover property (cp.count_tick && cur_ff.ctrl[timer_one_pkg::CTRL_SRC]);
endmodule // timer_one_core

// ### tb/count_source.sv
// far-side model: external count clock on pin 0, crystal on pin 1
// assumes the bench starts and stops it; the count line idles low and the unused line high between bursts
`timescale 1ns/100ps
module count_source #(
	parameter int HALF = 3
) (
	input  wire logic       sys_clk,
	input  wire logic       run,
	input  wire logic       xtal_on,
	output logic      [1:0] level,
	output int              rises
);
	////////////////////////////////////////
	logic ph;
	int   cnt;
	initial begin
		ph = 1'b0;
		cnt = 0;
		rises = 0;
	end
	// rising edges counted for the bench
	always @(posedge sys_clk) begin
		if (!run) begin
			ph <= 1'b0;
			cnt <= 0;
		end else if (cnt == HALF - 1) begin
			cnt <= 0;
			ph <= !ph;
			if (!ph)
				rises <= rises + 1;
		end else
			cnt <= cnt + 1;
	end
	// the unused line carries the inverse so a stale level cannot pass
	assign level = xtal_on ? {ph, !ph} : {!ph, ph};
endmodule // count_source

// ### tb/sixteen_bit_timer_counter_tb_top.sv
// self-checking bench for the sixteen-bit timer/counter
// assumes timer_one_core is the top and count_source stands at the pins
`timescale 1ns/100ps
module sixteen_bit_timer_counter_tb_top;
	logic        sys_clk = 1'b0, resetn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic        sleep_mode = 1'b0, trig = 1'b0, src_run = 1'b0, ack, irq, osc_en;
	logic [7:0]  adr = 8'h00, hi, lo;
	logic [3:0]  sel = 4'hF;
	logic [31:0] dat = 32'h0, dat_o, rd;
	logic [1:0]  pin_out, pin_oe, lvl, pin_in;
	logic [15:0] cnt, held;
	int          error_cnt = 0, n_tests = 0, rises, r0, c, d, seed = 32'h29AEF131;
	always #50 sys_clk = ~sys_clk;
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & lvl);
	timer_one_core u_dut (.sys_clk(sys_clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.sleep_mode(sleep_mode), .special_event_trigger(trig), .overflow_irq(irq),
		.low_power_osc_enable(osc_en), .count_value(cnt));
	count_source u_src (.sys_clk(sys_clk), .run(src_run), .xtal_on(osc_en), .level(lvl),
		.rises(rises));
	////////////////////////////////////////
	task finish_test;
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			error_cnt++;
		end
	endtask
	// expected count: one tick per instruction cycle, then the divider
	function automatic int ticks(input int cycles, input int div_code);
		return cycles / (timer_one_pkg::INSTR_DIV << div_code);
	endfunction
	// called just after a rising edge; holds the request until ack is sampled
	task wb(input logic w, input logic [7:0] a, input logic [31:0] v);
		int i;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= v;
		for (i = 0; i < 20; i++) begin
			@(posedge sys_clk);
			if (ack === 1'b1)
				break;
		end
		if (i == 20) begin
			error_cnt++;
			finish_test;
		end else begin
			rd = dat_o;
			cyc <= 1'b0;
			stb <= 1'b0;
			we <= 1'b0;
			@(posedge sys_clk);
		end
	endtask
	task clr;
		wb(1'b1, timer_one_pkg::OFS_COUNT_HIGH, 32'h0);
		wb(1'b1, timer_one_pkg::OFS_COUNT_LOW, 32'h0);
	endtask
	////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge sys_clk);
		error_cnt++;
		finish_test;
	end
	initial begin
		repeat (8) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		chk("count_rst", 32'h0, cnt);
		wb(1'b0, timer_one_pkg::OFS_CONTROL, 32'h0);
		chk("ctrl_rst", timer_one_pkg::CONTROL_RESET, rd);
		wb(1'b0, timer_one_pkg::OFS_PORT_C, 32'h0);
		chk("dir_rst", timer_one_pkg::PORT_DIR_RESET, rd[1:0]);
		wb(1'b0, 8'h3C, 32'h0);
		chk("unmapped", 32'h0, rd);
		wb(1'b1, timer_one_pkg::OFS_CONTROL, 32'hFF);
		wb(1'b0, timer_one_pkg::OFS_CONTROL, 32'h0);
		chk("ctrl_rb", timer_one_pkg::CONTROL_WMASK, rd);
		// every divider code, internal source, random bypass bit that must be ignored
		for (d = 0; d < 4; d++) begin
			c = 20 + $unsigned($random(seed)) % 20;
			r0 = timer_one_pkg::INSTR_DIV * (1 << d) * c;
			c = ticks(r0, d);
			clr;
			wb(1'b1, timer_one_pkg::OFS_CONTROL, 32'(d * 16 + 4 * ($unsigned($random(seed)) % 2) + 1));
			repeat (r0) @(posedge sys_clk);
			wb(1'b1, timer_one_pkg::OFS_CONTROL, 32'h0);
			chk("div_count", 32'h1, 32'((cnt >= c - 1) && (cnt <= c + 2)));
		end
		held = cnt;
		repeat (50) @(posedge sys_clk);
		chk("hold", held, cnt);
		wb(1'b1, timer_one_pkg::OFS_COUNT_HIGH, 32'hFF);
		wb(1'b1, timer_one_pkg::OFS_COUNT_LOW, 32'hFD);
		chk("stop_wr", 32'hFFFD, cnt);
		sel <= 4'hE;
		wb(1'b1, timer_one_pkg::OFS_COUNT_LOW, 32'h11);
		sel <= 4'hF;
		chk("sel_skip", 32'hFFFD, cnt);
		wb(1'b1, timer_one_pkg::OFS_FLAG, 32'h0);
		wb(1'b1, timer_one_pkg::OFS_CONTROL, 32'h1);
		repeat (40) @(posedge sys_clk);
		wb(1'b1, timer_one_pkg::OFS_CONTROL, 32'h0);
		chk("wrap", 32'h1, 32'(cnt < 16'h0010));
		wb(1'b0, timer_one_pkg::OFS_FLAG, 32'h0);
		chk("flag", 32'h1, rd);
		chk("irq_off", 32'h0, irq);
		wb(1'b1, timer_one_pkg::OFS_ENABLE, 32'h1);
		chk("irq_on", 32'h1, irq);
		wb(1'b1, timer_one_pkg::OFS_ENABLE, 32'h0);
		wb(1'b1, timer_one_pkg::OFS_FLAG, 32'h0);
		wb(1'b1, timer_one_pkg::OFS_COUNT_LOW, 32'h55);
		trig <= 1'b1;
		@(posedge sys_clk);
		trig <= 1'b0;
		repeat (2) @(posedge sys_clk);
		chk("trig_cnt", 32'h0, cnt);
		wb(1'b0, timer_one_pkg::OFS_FLAG, 32'h0);
		chk("trig_flag", 32'h0, rd);
		// trigger sampled on the same edge that takes the low write
		trig <= 1'b1;
		fork
			wb(1'b1, timer_one_pkg::OFS_COUNT_LOW, 32'h66);
			begin
				@(posedge sys_clk);
				trig <= 1'b0;
			end
		join
		chk("trig_wr", 32'h66, cnt);
		hi = 8'($random(seed));
		lo = 8'($random(seed));
		wb(1'b1, timer_one_pkg::OFS_CONTROL, 32'h80);
		wb(1'b1, timer_one_pkg::OFS_COUNT_HIGH, {24'h0, hi});
		chk("wide_buf", 32'h0, cnt[15:8]);
		wb(1'b1, timer_one_pkg::OFS_COUNT_LOW, {24'h0, lo});
		chk("wide_wr", {16'h0, hi, lo}, cnt);
		wb(1'b1, timer_one_pkg::OFS_COUNT_HIGH, {24'h0, ~hi});
		wb(1'b0, timer_one_pkg::OFS_COUNT_LOW, 32'h0);
		chk("wide_lo", {24'h0, lo}, rd);
		wb(1'b0, timer_one_pkg::OFS_COUNT_HIGH, 32'h0);
		chk("wide_hi", {24'h0, hi}, rd);
		// external pin, synchronised then bypassed
		for (c = 0; c < 2; c++) begin
			wb(1'b1, timer_one_pkg::OFS_CONTROL, 32'h0);
			clr;
			wb(1'b1, timer_one_pkg::OFS_CONTROL, (c == 1) ? 32'h07 : 32'h03);
			r0 = rises;
			src_run <= 1'b1;
			repeat (60 + $unsigned($random(seed)) % 60) @(posedge sys_clk);
			src_run <= 1'b0;
			repeat (10) @(posedge sys_clk);
			wb(1'b1, timer_one_pkg::OFS_CONTROL, 32'h0);
			chk("ext_count", 32'(rises - r0), cnt);
		end
		wb(1'b1, timer_one_pkg::OFS_PORT_C, 32'h0C);
		chk("oe_out", 32'h3, pin_oe);
		chk("pin_lat", 32'h3, pin_out);
		clr;
		wb(1'b1, timer_one_pkg::OFS_CONTROL, 32'h0F);
		chk("osc_on", 32'h1, osc_en);
		chk("oe_in", 32'h0, pin_oe);
		wb(1'b0, timer_one_pkg::OFS_PORT_C, 32'h0);
		chk("pin_rd", 32'h0, rd[5:4]);
		repeat (20) @(posedge sys_clk);
		r0 = rises;
		sleep_mode <= 1'b1;
		src_run <= 1'b1;
		repeat (90) @(posedge sys_clk);
		src_run <= 1'b0;
		repeat (10) @(posedge sys_clk);
		sleep_mode <= 1'b0;
		@(posedge sys_clk);
		chk("xtal_sleep", 32'(rises - r0), cnt);
		wb(1'b1, timer_one_pkg::OFS_CONTROL, 32'h0);
		chk("osc_off", 32'h0, osc_en);
		finish_test;
	end
endmodule // sixteen_bit_timer_counter_tb_top
